/* File: tmc16_pkg.sv */
//
// Contract
// - Sixteen-bit counter steps once per rising edge of the divided timer clock.
// - Software reads and writes the count; a write replaces it at once.
// - Clear control zeroes count, prescaler state and resets direction to up.
// - Timer clock is one of auxiliary, subsystem or two external clocks.
// - Prescaler divides the selected clock by 1, 2, 4 or 8.
// - Mode 00 stop, 01 up, 10 continuous, 11 up/down; counts only with active source.
// - Period zero halts up and up/down modes; nonzero period restarts upward from zero.
// - Up mode counts zero to period then wraps; period spans period plus one counts.
// - Up mode with count above period restarts from zero immediately.
// - Up mode sets match flag reaching period, rollover flag wrapping to zero.
// - Period change in up mode counts to new period or wraps to zero.
// - Continuous mode counts zero to ffff then wraps; period is a plain compare.
// - Continuous mode sets rollover flag on carry from ffff to zero.
// - Up/down mode counts up to period and back down to zero repeatedly.
// - Count direction is latched across stop and restart; only clear or a period restart from zero resets it.
// - Up/down match flag on period-1 to period, rollover on 0001 to 0000.
// - Period change while descending latches at once but applies after reaching zero.
// - Period change while ascending counts to new period or turns downward.
// - Direct counter writes set no flag and trigger no action.
// - Interrupt request raised per flag when its enable and global enable are set.
//
package tmc16_pkg;

  // ****************************************************************
  // Register map
  // ****************************************************************
  localparam logic [3:0] TMC16_OFF_CTRL = 4'h0;
  localparam logic [3:0] TMC16_OFF_COUNT = 4'h4;
  localparam logic [3:0] TMC16_OFF_PERIOD = 4'h8;
  localparam logic [3:0] TMC16_OFF_FLAGS = 4'hc;

  // Control fields
  localparam int TMC16_CTRL_CLR = 0;
  localparam int TMC16_CTRL_MODE_LO = 1;
  localparam int TMC16_CTRL_DIV_LO = 3;
  localparam int TMC16_CTRL_SRC_LO = 5;
  localparam int TMC16_CTRL_MIE = 7;
  localparam int TMC16_CTRL_RIE = 8;
  localparam int TMC16_CTRL_GIE = 9;
  localparam int TMC16_CTRL_DIR = 10;
  // Flag fields, write one to clear
  localparam int TMC16_FLAG_MATCH = 0;
  localparam int TMC16_FLAG_ROLL = 1;

  localparam logic [15:0] TMC16_COUNT_RST = 16'h0000;
  localparam logic [15:0] TMC16_COUNT_MAX = 16'hffff;
  localparam logic [15:0] TMC16_COUNT_ONE = 16'h0001;
  localparam logic [2:0] TMC16_DIV_RST = 3'h0;
  localparam logic [31:0] TMC16_UNMAPPED = 32'h0000_0000;

  typedef enum logic [1:0] {
    TMC16_MODE_STOP = 2'h0,
    TMC16_MODE_UP = 2'h1,
    TMC16_MODE_CONT = 2'h2,
    TMC16_MODE_UPDN = 2'h3
  } tmc16_mode_t;

  typedef enum logic [1:0] {
    TMC16_SRC_AUX = 2'h0,
    TMC16_SRC_SUB = 2'h1,
    TMC16_SRC_EXTA = 2'h2,
    TMC16_SRC_EXTB = 2'h3
  } tmc16_src_t;

  // Bus access state, one-hot
  typedef enum logic [1:0] {
    TMC16_BUS_IDLE = 2'b01,
    TMC16_BUS_DONE = 2'b10
  } tmc16_bus_t;

  typedef struct packed {
    logic match;
    logic roll;
  } tmc16_irq_t;

endpackage : tmc16_pkg

/* File: tmc16_timer.sv */
// Register access over Avalon-MM and the register addresses were left to the implementer.
`timescale 1ns/10ps
module tmc16_timer (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // Timer clock sources, asynchronous to clk_sys
  input wire logic aux_clock,
  input wire logic subsystem_clock,
  input wire logic ext_clock_a,
  input wire logic ext_clock_b,
  // Avalon-MM slave
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // Events and interrupt requests
  output logic [15:0] count_value,
  output logic match_pulse,
  output tmc16_pkg::tmc16_irq_t irq
);
  import tmc16_pkg::*;

  // ****************************************************************
  // Configuration state
  // ****************************************************************
  logic [1:0] count_mode_select;
  logic [1:0] prescale_select;
  logic [1:0] clock_source_select;
  logic match_irq_enable;
  logic roll_irq_enable;
  logic global_irq_enable;
  logic [15:0] period_register;
  logic [15:0] period_latch;
  logic match_flag;
  logic rollover_flag;
  logic dir_down;
  logic [2:0] div_count;
  tmc16_bus_t bus_state;

  // ****************************************************************
  // Source selection and synchroniser
  // ****************************************************************
  logic src_raw;
  always_comb begin
    case (tmc16_src_t'(clock_source_select))
      TMC16_SRC_AUX: src_raw = aux_clock;
      TMC16_SRC_SUB: src_raw = subsystem_clock;
      TMC16_SRC_EXTA: src_raw = ext_clock_a;
      default: src_raw = ext_clock_b;
    endcase
  end

  // Three stages; the edge counts once stages two and three agree high
  logic [2:0] src_sync;
  logic src_level;
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      src_sync <= 3'h0;
      src_level <= 1'b0;
    end else begin
      src_sync <= {src_sync[1:0], src_raw};
      if (src_sync[2] == src_sync[1]) begin
        src_level <= src_sync[2];
      end
    end
  end
  logic src_rise;
  assign src_rise = (src_sync[2] == src_sync[1]) && src_sync[2] && !src_level;

  // ****************************************************************
  // Bus decode
  // ****************************************************************
  logic wr_ctrl, wr_count, wr_period, wr_flags, clr_req;
  assign wr_ctrl = avs_write && bus_state == TMC16_BUS_IDLE && avs_address == TMC16_OFF_CTRL
                   && avs_byteenable[0];
  assign wr_count = avs_write && bus_state == TMC16_BUS_IDLE
                    && avs_address == TMC16_OFF_COUNT && avs_byteenable[0];
  assign wr_period = avs_write && bus_state == TMC16_BUS_IDLE
                     && avs_address == TMC16_OFF_PERIOD && avs_byteenable[0];
  assign wr_flags = avs_write && bus_state == TMC16_BUS_IDLE
                    && avs_address == TMC16_OFF_FLAGS && avs_byteenable[0];
  // Clear is self-clearing: it acts in the write cycle and never stores
  assign clr_req = wr_ctrl && avs_writedata[TMC16_CTRL_CLR];

  // ****************************************************************
  // Prescaler
  // ****************************************************************
  logic div_tick;
  logic [2:0] div_mask;
  assign div_mask = 3'((4'h1 << prescale_select) - 4'h1);
  assign div_tick = src_rise && ((div_count & div_mask) == div_mask);

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      div_count <= TMC16_DIV_RST;
    end else if (clr_req) begin
      div_count <= TMC16_DIV_RST;
    end else if (src_rise) begin
      div_count <= (div_tick) ? TMC16_DIV_RST : div_count + 3'h1;
    end
  end

  // ****************************************************************
  // Counting engine
  // ****************************************************************
  logic [15:0] next_count;
  logic next_dir_down;
  logic step;
  logic hit_match, hit_roll;
  logic [15:0] limit;
  tmc16_mode_t mode;
  assign mode = tmc16_mode_t'(count_mode_select);
  // Descending uses the latched copy so a new period waits for zero
  assign limit = dir_down ? period_latch : period_register;

  // Period zero in up or up/down modes halts counting
  assign step = div_tick && mode != TMC16_MODE_STOP
                && !((mode == TMC16_MODE_UP || mode == TMC16_MODE_UPDN)
                     && period_register == TMC16_COUNT_RST);

  always_comb begin
    next_count = count_value;
    next_dir_down = dir_down;
    hit_match = 1'b0;
    hit_roll = 1'b0;
    case (mode)
      TMC16_MODE_UP: begin
        if (count_value >= period_register) begin
          next_count = TMC16_COUNT_RST;
          hit_roll = (count_value == period_register);
        end else begin
          next_count = count_value + TMC16_COUNT_ONE;
          hit_match = (next_count == period_register);
        end
      end
      TMC16_MODE_CONT: begin
        next_count = count_value + TMC16_COUNT_ONE;
        hit_roll = (count_value == TMC16_COUNT_MAX);
        hit_match = (next_count == period_register);
      end
      TMC16_MODE_UPDN: begin
        if (dir_down) begin
          if (count_value == TMC16_COUNT_RST) begin
            next_dir_down = 1'b0;
            next_count = TMC16_COUNT_ONE;
            hit_match = (period_register == TMC16_COUNT_ONE);
          end else begin
            next_count = count_value - TMC16_COUNT_ONE;
            hit_roll = (count_value == TMC16_COUNT_ONE);
            next_dir_down = !(next_count == TMC16_COUNT_RST);
          end
        end else if (count_value >= limit) begin
          next_dir_down = 1'b1;
          next_count = count_value - TMC16_COUNT_ONE;
          hit_roll = (count_value == TMC16_COUNT_ONE);
        end else begin
          next_count = count_value + TMC16_COUNT_ONE;
          hit_match = (next_count == period_register);
        end
      end
      default: next_count = count_value;
    endcase
  end

  // Counter: clear beats bus write beats counting
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      count_value <= TMC16_COUNT_RST;
    end else if (clr_req) begin
      count_value <= TMC16_COUNT_RST;
    end else if (wr_count) begin
      count_value <= avs_writedata[15:0];
    end else if (wr_period && period_register == TMC16_COUNT_RST
                 && (mode == TMC16_MODE_UP || mode == TMC16_MODE_UPDN)) begin
      count_value <= TMC16_COUNT_RST;
    end else if (step) begin
      count_value <= next_count;
    end
  end

  // Direction latch survives stop; only clear or a period restart resets it
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      dir_down <= 1'b0;
    end else if (clr_req) begin
      dir_down <= 1'b0;
    end else if (wr_period && period_register == TMC16_COUNT_RST) begin
      dir_down <= 1'b0;
    end else if (step && !wr_count) begin
      dir_down <= next_dir_down;
    end
  end

  // Working period copy, refreshed at zero while descending
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      period_latch <= TMC16_COUNT_RST;
    end else if (!dir_down || count_value == TMC16_COUNT_RST) begin
      period_latch <= period_register;
    end
  end

  // ****************************************************************
  // Flags and interrupt requests
  // ****************************************************************
  logic ev_match, ev_roll;
  // Direct writes of the counter never produce events
  assign ev_match = step && !wr_count && !clr_req && hit_match;
  assign ev_roll = step && !wr_count && !clr_req && hit_roll;

  // Set beats clear in the same cycle
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      match_flag <= 1'b0;
      rollover_flag <= 1'b0;
    end else begin
      match_flag <= ev_match
                    || (match_flag && !(wr_flags && avs_writedata[TMC16_FLAG_MATCH]));
      rollover_flag <= ev_roll
                       || (rollover_flag && !(wr_flags && avs_writedata[TMC16_FLAG_ROLL]));
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      irq <= '0;
      match_pulse <= 1'b0;
    end else begin
      irq.match <= match_flag && match_irq_enable && global_irq_enable;
      irq.roll <= rollover_flag && roll_irq_enable && global_irq_enable;
      match_pulse <= ev_match;
    end
  end

  // ****************************************************************
  // Configuration registers
  // ****************************************************************
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      count_mode_select <= 2'h0;
      prescale_select <= 2'h0;
      clock_source_select <= 2'h0;
      match_irq_enable <= 1'b0;
      roll_irq_enable <= 1'b0;
      global_irq_enable <= 1'b0;
    end else if (wr_ctrl) begin
      count_mode_select <= avs_writedata[TMC16_CTRL_MODE_LO +: 2];
      prescale_select <= avs_writedata[TMC16_CTRL_DIV_LO +: 2];
      clock_source_select <= avs_writedata[TMC16_CTRL_SRC_LO +: 2];
      match_irq_enable <= avs_writedata[TMC16_CTRL_MIE];
      roll_irq_enable <= avs_writedata[TMC16_CTRL_RIE];
      global_irq_enable <= avs_writedata[TMC16_CTRL_GIE];
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      period_register <= TMC16_COUNT_RST;
    end else if (wr_period) begin
      period_register <= avs_writedata[15:0];
    end
  end

  // ****************************************************************
  // Bus answer: every access completes one cycle after it is taken
  // ****************************************************************
  logic [31:0] rd_mux;
  always_comb begin
    rd_mux = TMC16_UNMAPPED;
    case (avs_address)
      TMC16_OFF_CTRL: begin
        rd_mux[TMC16_CTRL_MODE_LO +: 2] = count_mode_select;
        rd_mux[TMC16_CTRL_DIV_LO +: 2] = prescale_select;
        rd_mux[TMC16_CTRL_SRC_LO +: 2] = clock_source_select;
        rd_mux[TMC16_CTRL_MIE] = match_irq_enable;
        rd_mux[TMC16_CTRL_RIE] = roll_irq_enable;
        rd_mux[TMC16_CTRL_GIE] = global_irq_enable;
        rd_mux[TMC16_CTRL_DIR] = dir_down;
      end
      TMC16_OFF_COUNT: rd_mux[15:0] = count_value;
      TMC16_OFF_PERIOD: rd_mux[15:0] = period_register;
      TMC16_OFF_FLAGS: begin
        rd_mux[TMC16_FLAG_MATCH] = match_flag;
        rd_mux[TMC16_FLAG_ROLL] = rollover_flag;
      end
      default: rd_mux = TMC16_UNMAPPED;
    endcase
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      bus_state <= TMC16_BUS_IDLE;
      avs_waitrequest <= 1'b1;
      avs_readdata <= TMC16_UNMAPPED;
    end else begin
      case (bus_state)
        TMC16_BUS_IDLE: begin
          if (avs_read || avs_write) begin
            bus_state <= TMC16_BUS_DONE;
            avs_waitrequest <= 1'b0;
            avs_readdata <= rd_mux;
          end
        end
        TMC16_BUS_DONE: begin
          bus_state <= TMC16_BUS_IDLE;
          avs_waitrequest <= 1'b1;
        end
        default: begin
          bus_state <= TMC16_BUS_IDLE;
          avs_waitrequest <= 1'b1;
        end
      endcase
    end
  end

  // ****************************************************************
  // Checks
  // ****************************************************************
  a_clear_zeroes: assert property (@(posedge clk_sys) disable iff (!rst_n)
    clr_req |=> count_value == TMC16_COUNT_RST && !dir_down)
    else $error("clear did not zero counter and direction");
  a_write_direct: assert property (@(posedge clk_sys) disable iff (!rst_n)
    wr_count && !clr_req |=> count_value == $past(avs_writedata[15:0]))
    else $error("counter write not immediate");
  a_stop_holds: assert property (@(posedge clk_sys) disable iff (!rst_n)
    mode == TMC16_MODE_STOP && !wr_count && !clr_req && !wr_period |=> $stable(count_value))
    else $error("counter moved while stopped");
  a_up_wrap: assert property (@(posedge clk_sys) disable iff (!rst_n)
    step && mode == TMC16_MODE_UP && count_value == period_register && !wr_count && !clr_req
    |=> count_value == TMC16_COUNT_RST && rollover_flag)
    else $error("up mode did not wrap with rollover");
  a_cont_carry: assert property (@(posedge clk_sys) disable iff (!rst_n)
    step && mode == TMC16_MODE_CONT && count_value == TMC16_COUNT_MAX && !wr_count && !clr_req
    |=> count_value == TMC16_COUNT_RST && rollover_flag)
    else $error("continuous carry missed rollover");
  a_updn_roll: assert property (@(posedge clk_sys) disable iff (!rst_n)
    step && mode == TMC16_MODE_UPDN && dir_down && count_value == TMC16_COUNT_ONE
    && !wr_count && !clr_req |=> count_value == TMC16_COUNT_RST && rollover_flag)
    else $error("up/down rollover missed");
  a_write_quiet: assert property (@(posedge clk_sys) disable iff (!rst_n)
    wr_count && !match_flag && !rollover_flag && !ev_match |=> !match_flag && !rollover_flag)
    else $error("direct write raised a flag");
  a_flag_sticky: assert property (@(posedge clk_sys) disable iff (!rst_n)
    match_flag && !wr_flags |=> match_flag)
    else $error("match flag dropped without clear");
  a_irq_gate: assert property (@(posedge clk_sys) disable iff (!rst_n)
    rollover_flag && roll_irq_enable && global_irq_enable |=> irq.roll)
    else $error("rollover request missing");
  a_bus_answer: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (avs_read || avs_write) && avs_waitrequest |-> ##[1:2] !avs_waitrequest)
    else $error("bus answer late");
  // A zero period must freeze the count until a nonzero period restarts it
  a_period_halt: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (mode == TMC16_MODE_UP || mode == TMC16_MODE_UPDN) && period_register == TMC16_COUNT_RST
    && !wr_count && !clr_req && !wr_period |=> $stable(count_value))
    else $error("counter moved with zero period");
  a_dir_latched: assert property (@(posedge clk_sys) disable iff (!rst_n)
    !clr_req && !step && !wr_period |=> $stable(dir_down))
    else $error("direction changed without counting");
  a_updn_match: assert property (@(posedge clk_sys) disable iff (!rst_n)
    step && mode == TMC16_MODE_UPDN && !dir_down && count_value < period_register
    && next_count == period_register && !wr_count && !clr_req |=> match_flag)
    else $error("up/down match missed");
  a_roll_sticky: assert property (@(posedge clk_sys) disable iff (!rst_n)
    rollover_flag && !wr_flags |=> rollover_flag)
    else $error("rollover flag dropped without clear");
  c_period_restart: cover property (@(posedge clk_sys) disable iff (!rst_n)
    wr_period && period_register == TMC16_COUNT_RST);
  c_up_wrap: cover property (@(posedge clk_sys) disable iff (!rst_n) ev_roll && mode == TMC16_MODE_UP);
  c_updn_turn: cover property (@(posedge clk_sys) disable iff (!rst_n) $rose(dir_down));
  c_cont_carry: cover property (@(posedge clk_sys) disable iff (!rst_n)
    ev_roll && mode == TMC16_MODE_CONT);
  c_clear_run: cover property (@(posedge clk_sys) disable iff (!rst_n) clr_req && step);

endmodule : tmc16_timer

/* File: tmc16_timer_test.sv */
`timescale 1ns/10ps
module tmc16_timer_test;
  import tmc16_pkg::*;

  // ****************************************************************
  // Stimulus and observation
  // ****************************************************************
  typedef struct packed {
    logic [1:0] mode;
    logic [1:0] div;
    logic [1:0] src;
    logic [1:0] tk;
    logic [15:0] per;
    logic [7:0] n;
    logic [15:0] cnt;
    logic [1:0] flg;
  } tmc16_row_t;

  logic clk_sys;
  logic rst_n;
  logic [3:0] src_line;
  logic [3:0] avs_address;
  logic avs_read;
  logic avs_write;
  logic [31:0] avs_writedata;
  logic [3:0] avs_byteenable;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic [15:0] count_value;
  logic match_pulse;
  tmc16_irq_t irq;
  logic [31:0] q;
  int bad_count;
  int samples_checked;
  int pulse_cnt;
  tmc16_row_t rows [8];

  tmc16_timer dut_u (
    .clk_sys(clk_sys), .rst_n(rst_n),
    .aux_clock(src_line[0]), .subsystem_clock(src_line[1]),
    .ext_clock_a(src_line[2]), .ext_clock_b(src_line[3]),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .count_value(count_value), .match_pulse(match_pulse), .irq(irq)
  );

  initial begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end

  always @(posedge clk_sys) begin
    if (match_pulse === 1'b1) pulse_cnt++;
  end

  // ****************************************************************
  // Tasks
  // ****************************************************************
  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
    samples_checked++;
    if (seen !== exp) begin
      bad_count++;
      $display("CHECK FAILED at %0t: %s seen %h expected %h", $time, msg, seen, exp);
    end
  endtask : check

  // Holds the request until waitrequest is sampled low, then idles one edge
  task automatic bus_acc(input logic wr, input logic [3:0] a, input logic [31:0] d,
                         input logic [3:0] be, output logic [31:0] rq);
    avs_address <= a;
    avs_writedata <= d;
    avs_byteenable <= be;
    if (wr) avs_write <= 1'b1;
    else avs_read <= 1'b1;
    @(posedge clk_sys);
    // Only the watchdog ends a wait that never gets an answer
    while (avs_waitrequest !== 1'b0) begin
      @(posedge clk_sys);
    end
    rq = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    @(posedge clk_sys);
  endtask : bus_acc

  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    logic [31:0] dummy;
    bus_acc(1'b1, a, d, 4'hf, dummy);
  endtask : wr

  task automatic rd(input logic [3:0] a, output logic [31:0] rq);
    bus_acc(1'b0, a, 32'h0000_0000, 4'hf, rq);
  endtask : rd

  // Source held 4 clk high and 4 clk low, above the synchroniser minimum
  task automatic tick(input logic [1:0] sel, input int n);
    repeat (n) begin
      src_line[sel] <= 1'b1;
      repeat (4) @(posedge clk_sys);
      src_line[sel] <= 1'b0;
      repeat (4) @(posedge clk_sys);
    end
    repeat (4) @(posedge clk_sys);
  endtask : tick

  function automatic logic [31:0] ctl(input logic [1:0] m, input logic [1:0] d,
                                      input logic [1:0] s, input logic [31:0] x);
    return x | (32'(m) << TMC16_CTRL_MODE_LO) | (32'(d) << TMC16_CTRL_DIV_LO)
             | (32'(s) << TMC16_CTRL_SRC_LO);
  endfunction : ctl

  task automatic restart(input logic [15:0] per);
    wr(TMC16_OFF_CTRL, 32'h0000_0001);
    wr(TMC16_OFF_FLAGS, 32'h0000_0003);
    wr(TMC16_OFF_PERIOD, 32'(per));
  endtask : restart

  task automatic final_report;
    $display("checked %0d, mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : final_report

  initial begin
    #200000;
    bad_count++;
    final_report();
  end

  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial begin
    rst_n = 1'b0;
    src_line = 4'h0;
    avs_address = 4'h0;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0000_0000;
    avs_byteenable = 4'h0;
    bad_count = 0;
    samples_checked = 0;
    pulse_cnt = 0;
    // mode, div, src, tick line, period, ticks, count, flags {roll, match}
    rows[0] = {TMC16_MODE_UP, 2'h0, 2'h0, 2'h0, 16'h0005, 8'h03, 16'h0003, 2'h0};
    rows[1] = {TMC16_MODE_UP, 2'h0, 2'h0, 2'h0, 16'h0005, 8'h06, 16'h0000, 2'h3};
    rows[2] = {TMC16_MODE_UP, 2'h0, 2'h0, 2'h0, 16'h0005, 8'h08, 16'h0002, 2'h3};
    rows[3] = {TMC16_MODE_CONT, 2'h1, 2'h1, 2'h1, 16'h1234, 8'h06, 16'h0003, 2'h0};
    rows[4] = {TMC16_MODE_UPDN, 2'h2, 2'h2, 2'h2, 16'h0003, 8'h14, 16'h0001, 2'h1};
    rows[5] = {TMC16_MODE_UPDN, 2'h3, 2'h3, 2'h3, 16'h0002, 8'h28, 16'h0001, 2'h3};
    rows[6] = {TMC16_MODE_STOP, 2'h0, 2'h0, 2'h0, 16'h0005, 8'h04, 16'h0000, 2'h0};
    rows[7] = {TMC16_MODE_CONT, 2'h0, 2'h1, 2'h0, 16'h1234, 8'h04, 16'h0000, 2'h0};
    repeat (3) @(posedge clk_sys);
    check(avs_waitrequest, 1'b1, "waitrequest in reset");
    check(count_value, TMC16_COUNT_RST, "count in reset");
    check(irq, 2'b00, "irq in reset");
    repeat (3) @(posedge clk_sys);
    rst_n <= 1'b1;
    @(posedge clk_sys);
    rd(TMC16_OFF_FLAGS, q);
    check(q, 32'h0000_0000, "flags after reset");
    $display("test reset done");

    foreach (rows[i]) begin
      restart(rows[i].per);
      wr(TMC16_OFF_CTRL, ctl(rows[i].mode, rows[i].div, rows[i].src, 32'h0));
      tick(rows[i].tk, rows[i].n);
      rd(TMC16_OFF_COUNT, q);
      check(q, 32'(rows[i].cnt), "row count");
      rd(TMC16_OFF_FLAGS, q);
      check(q[1:0], rows[i].flg, "row flags");
      check(count_value, rows[i].cnt, "row count port");
    end
    $display("test table done");

    restart(16'h1234);
    wr(TMC16_OFF_COUNT, 32'h0000_fffe);
    check(count_value, 16'hfffe, "direct count write");
    rd(TMC16_OFF_FLAGS, q);
    check(q, 32'h0000_0000, "flags after direct write");
    wr(TMC16_OFF_CTRL, ctl(TMC16_MODE_CONT, 2'h0, 2'h0, 32'h0));
    tick(2'h0, 2);
    check(count_value, 16'h0000, "carry from ffff");
    rd(TMC16_OFF_FLAGS, q);
    check(q, 32'h0000_0002, "rollover on carry");
    bus_acc(1'b1, TMC16_OFF_COUNT, 32'h0000_0077, 4'h0, q);
    check(count_value, 16'h0000, "write without lane 0");
    rd(4'h2, q);
    check(q, TMC16_UNMAPPED, "unmapped read");
    $display("test continuous done");

    restart(16'h0005);
    wr(TMC16_OFF_COUNT, 32'h0000_000a);
    wr(TMC16_OFF_CTRL, ctl(TMC16_MODE_UP, 2'h0, 2'h0, 32'h0));
    tick(2'h0, 1);
    check(count_value, 16'h0000, "up above period");
    restart(16'h0008);
    wr(TMC16_OFF_CTRL, ctl(TMC16_MODE_UP, 2'h0, 2'h0, 32'h0));
    tick(2'h0, 5);
    wr(TMC16_OFF_PERIOD, 32'h0000_000a);
    tick(2'h0, 5);
    check(count_value, 16'h000a, "longer period reached");
    tick(2'h0, 1);
    check(count_value, 16'h0000, "wrap after new period");
    $display("test up done");

    restart(16'h0003);
    wr(TMC16_OFF_CTRL, ctl(TMC16_MODE_UPDN, 2'h0, 2'h0, 32'h0));
    tick(2'h0, 4);
    wr(TMC16_OFF_CTRL, ctl(TMC16_MODE_STOP, 2'h0, 2'h0, 32'h0));
    rd(TMC16_OFF_CTRL, q);
    check(q[TMC16_CTRL_DIR], 1'b1, "direction held down");
    wr(TMC16_OFF_CTRL, ctl(TMC16_MODE_UPDN, 2'h0, 2'h0, 32'h0));
    tick(2'h0, 1);
    check(count_value, 16'h0001, "resume downward");
    wr(TMC16_OFF_CTRL, ctl(TMC16_MODE_UPDN, 2'h0, 2'h0, 32'h1));
    check(count_value, 16'h0000, "clear zeroes count");
    rd(TMC16_OFF_CTRL, q);
    check(q[TMC16_CTRL_DIR], 1'b0, "clear sets up");
    wr(TMC16_OFF_PERIOD, 32'h0000_0000);
    tick(2'h0, 2);
    check(count_value, 16'h0000, "zero period halts");
    wr(TMC16_OFF_PERIOD, 32'h0000_0004);
    tick(2'h0, 5);
    check(count_value, 16'h0003, "restart upward");
    wr(TMC16_OFF_PERIOD, 32'h0000_0006);
    rd(TMC16_OFF_PERIOD, q);
    check(q, 32'h0000_0006, "period latched");
    tick(2'h0, 3);
    check(count_value, 16'h0000, "descent kept");
    tick(2'h0, 6);
    check(count_value, 16'h0006, "new period after zero");
    $display("test up down done");

    restart(16'h0002);
    wr(TMC16_OFF_CTRL, ctl(TMC16_MODE_UP, 2'h0, 2'h0, 32'h0000_0180));
    pulse_cnt = 0;
    tick(2'h0, 9);
    check(pulse_cnt, 3, "match pulses");
    check(irq, 2'b00, "irq without global enable");
    wr(TMC16_OFF_CTRL, ctl(TMC16_MODE_UP, 2'h0, 2'h0, 32'h0000_0380));
    repeat (2) @(posedge clk_sys);
    check(irq, 2'b11, "irq both enabled");
    wr(TMC16_OFF_FLAGS, 32'h0000_0001);
    repeat (2) @(posedge clk_sys);
    check(irq, 2'b01, "irq after match clear");
    rd(TMC16_OFF_FLAGS, q);
    check(q, 32'h0000_0002, "rollover kept");
    $display("test interrupt done");

    wr(TMC16_OFF_COUNT, 32'h0000_0055);
    rst_n <= 1'b0;
    repeat (2) @(posedge clk_sys);
    check(count_value, TMC16_COUNT_RST, "count in mid-run reset");
    check(irq, 2'b00, "irq in mid-run reset");
    check(avs_waitrequest, 1'b1, "waitrequest in mid-run reset");
    rst_n <= 1'b1;
    @(posedge clk_sys);
    rd(TMC16_OFF_FLAGS, q);
    check(q, 32'h0000_0000, "flags after mid-run reset");
    rd(TMC16_OFF_CTRL, q);
    check(q, 32'h0000_0000, "control after mid-run reset");
    $display("test mid-run reset done");
    final_report();
  end

endmodule : tmc16_timer_test
